// [framing_opts_pkg.sv]
package framing_opts_pkg;
   localparam int unsigned ADDR_W = 12;
   // register indices; the bus byte address is four times the index
   localparam logic [11:0] TYPE_BF_OFFSET   = 12'h007;
   localparam logic [11:0] STREAM_OFFSET    = 12'h008;
   localparam logic [11:0] AUX_OFFSET       = 12'h009;
   localparam logic [11:0] STATUS_OFFSET    = 12'h010;
   // index to byte address
   localparam int unsigned WORD_SHIFT = 2;

   localparam logic [7:0] TYPE_BF_RESET = 8'h00;
   localparam logic [7:0] STREAM_RESET  = 8'h00;
   localparam logic [7:0] AUX_RESET     = 8'h04;
   localparam logic [7:0] STREAM_MASK   = 8'h7f;

   // type b / f register fields
   localparam int unsigned TR1_HI   = 7;
   localparam int unsigned TR1_LO   = 6;
   localparam int unsigned NO_SOF   = 5;
   localparam int unsigned NO_EOF   = 4;
   localparam int unsigned EOF_EXT  = 3;
   localparam int unsigned PHC_BIT  = 2;
   localparam int unsigned PRE_HI   = 1;
   localparam int unsigned PRE_LO   = 0;
   // stream register fields
   localparam int unsigned SCF_HI   = 6;
   localparam int unsigned SCF_LO   = 5;
   localparam int unsigned SCP_HI   = 4;
   localparam int unsigned SCP_LO   = 3;
   localparam int unsigned STX_HI   = 2;
   localparam int unsigned STX_LO   = 0;
   // auxiliary register fields
   localparam int unsigned SKIP_CRC = 7;
   localparam int unsigned CRC_BUF  = 6;
   localparam int unsigned MOD_AM   = 5;
   localparam int unsigned FD_EN    = 4;
   localparam int unsigned OOK_TRI  = 3;
   localparam int unsigned RX_TOL   = 2;
   localparam int unsigned FON_HI   = 1;
   localparam int unsigned FON_LO   = 0;

   // decoded figures
   localparam logic [6:0] TR1_LONG   = 7'd80;
   localparam logic [6:0] TR1_MID    = 7'd64;
   localparam logic [6:0] TR1_SHORT  = 7'd32;
   localparam logic [6:0] PRE_BASE   = 7'd48;
   localparam logic [6:0] PRE_STEP   = 7'd16;
   localparam logic [3:0] EOF_MIN    = 4'd10;
   localparam logic [3:0] EOF_MAX    = 4'd11;
   localparam logic [3:0] EOF_MAX_X  = 4'd12;
   // sub-carrier divider of fc, log2
   localparam logic [2:0] DIV_128    = 3'd7;
   localparam logic [2:0] DIV_64     = 3'd6;
   localparam logic [2:0] DIV_32     = 3'd5;
   localparam logic [2:0] DIV_16     = 3'd4;

   typedef enum logic [1:0] {
      RATE_128,
      RATE_64,
      RATE_32,
      RATE_16
   } bit_rate_t;
endpackage : framing_opts_pkg

// [option_reg.sv]
module option_reg #(
   parameter int unsigned WIDTH = 8,
   parameter logic [7:0]  RESET = 8'h00,
   parameter logic [7:0]  MASK  = 8'hff
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic             setDefault,
   input  wire logic             wrEn,
   input  wire logic [WIDTH-1:0] wrData,
   input  wire logic             presetEn,
   input  wire logic [WIDTH-1:0] presetMask,
   input  wire logic [WIDTH-1:0] presetData,
   output logic      [WIDTH-1:0] value
);
   // software write beats a preset in the same cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst || setDefault) begin
         value <= RESET[WIDTH-1:0];
      end else if (wrEn) begin
         value <= wrData & MASK[WIDTH-1:0];
      end else if (presetEn) begin
         value <= (value & ~presetMask) | (presetData & presetMask);
      end
   end
endmodule : option_reg

// [edge_decode.sv]
module edge_decode (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       eofExtend,
   input  framing_opts_pkg::bit_rate_t rate,
   output logic      [3:0] eofMaxEtu
);
   // above fc/32 one sub-carrier period per bit cannot split 11 and 12 etu
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         eofMaxEtu <= framing_opts_pkg::EOF_MAX;
      end else if (eofExtend && rate != framing_opts_pkg::RATE_16) begin
         eofMaxEtu <= framing_opts_pkg::EOF_MAX_X;
      end else begin
         eofMaxEtu <= framing_opts_pkg::EOF_MAX;
      end
   end
endmodule : edge_decode

// [nfc_framing_option_registers.sv]
// Summary of operation
// - tr1 code picks minimum response time
// - bit five drops card start-of-frame
// - bit four drops card end-of-frame
// - extended eof accepts 10 to 12 etu
// - extension ignored at fc/16 and faster
// - bit two widens phase change tolerance
// - preamble 48/64/80/96, also active mode
// - set-default restores defaults, tolerance one
// - sub-carrier frequency per stream mode
// - report period 1, 2, 4, 8 pulses
// - transmit period fc/128 down to fc/16
// - skip-crc bit disables receive crc check
// - reqa, wupa, anticollision force no crc
// - crc-to-buffer stores crc, still checks
// - modulation bit OOK/AM, preset settable
// - field detector enable drives detector
// - tristate antenna drivers during OOK
// - tolerant decoding when tolerance bit set: bpsk at fc/32, first byte at fc/128 without bpsk
// - field-on parameter n for commands
module nfc_framing_option_registers (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   input  wire logic        setDefaultCmd,
   input  wire logic        analogPresetCmd,
   input  wire logic        presetAm,
   input  wire logic        reqaWupaSent,
   input  wire logic        antiCollision,
   input  wire logic        bpskMode,
   input  wire logic        ookActive,
   input  framing_opts_pkg::bit_rate_t rxRate,
   output logic      [6:0]  minResponseTime,
   output logic             expectSof,
   output logic             expectEof,
   output logic      [3:0]  eofMaxEtu,
   output logic             phaseToleranceWide,
   output logic      [6:0]  preambleLength,
   output logic      [2:0]  subcarrierDivLog2,
   output logic             subcarrierValid,
   output logic      [3:0]  reportPulses,
   output logic      [2:0]  txPeriodDivLog2,
   output logic             txPeriodValid,
   output logic             rxCrcCheck,
   output logic             crcToFifo,
   output logic             modulationAm,
   output logic             fieldDetectorOn,
   output logic             antennaDriverTristate,
   output logic             bpskTolerant,
   output logic             firstByteTolerant,
   output logic      [1:0]  fieldOnParameter
);
   logic [7:0] typeBf;
   logic [7:0] stream;
   logic [7:0] aux;
   logic       access;
   logic       wrTypeBf;
   logic       wrStream;
   logic       wrAux;
   logic       mapped;

   // one register to a word: the byte address is four times the index
   localparam logic [11:0] TYPE_BF_ADDR =
      framing_opts_pkg::TYPE_BF_OFFSET << framing_opts_pkg::WORD_SHIFT;
   localparam logic [11:0] STREAM_ADDR =
      framing_opts_pkg::STREAM_OFFSET << framing_opts_pkg::WORD_SHIFT;
   localparam logic [11:0] AUX_ADDR =
      framing_opts_pkg::AUX_OFFSET << framing_opts_pkg::WORD_SHIFT;
   localparam logic [11:0] STATUS_ADDR =
      framing_opts_pkg::STATUS_OFFSET << framing_opts_pkg::WORD_SHIFT;

   assign access   = psel && penable;
   assign wrTypeBf = access && pwrite && pstrb[0]
                     && paddr == TYPE_BF_ADDR;
   assign wrStream = access && pwrite && pstrb[0]
                     && paddr == STREAM_ADDR;
   assign wrAux    = access && pwrite && pstrb[0]
                     && paddr == AUX_ADDR;
   assign mapped   = paddr == TYPE_BF_ADDR
                  || paddr == STREAM_ADDR
                  || paddr == AUX_ADDR
                  || paddr == STATUS_ADDR;
   // zero wait states; pslverr only during the access phase
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   option_reg #(
      .WIDTH (8),
      .RESET (framing_opts_pkg::TYPE_BF_RESET),
      .MASK  (8'hff)
   ) uTypeBf (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .setDefault (setDefaultCmd),
      .wrEn       (wrTypeBf),
      .wrData     (pwdata[7:0]),
      .presetEn   (1'b0),
      .presetMask (8'h00),
      .presetData (8'h00),
      .value      (typeBf)
   );

   option_reg #(
      .WIDTH (8),
      .RESET (framing_opts_pkg::STREAM_RESET),
      .MASK  (framing_opts_pkg::STREAM_MASK)
   ) uStream (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .setDefault (setDefaultCmd),
      .wrEn       (wrStream),
      .wrData     (pwdata[7:0]),
      .presetEn   (1'b0),
      .presetMask (8'h00),
      .presetData (8'h00),
      .value      (stream)
   );

   option_reg #(
      .WIDTH (8),
      .RESET (framing_opts_pkg::AUX_RESET),
      .MASK  (8'hff)
   ) uAux (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .setDefault (setDefaultCmd),
      .wrEn       (wrAux),
      .wrData     (pwdata[7:0]),
      .presetEn   (analogPresetCmd),
      .presetMask (8'(1) << framing_opts_pkg::MOD_AM),
      .presetData ({7'h00, presetAm} << framing_opts_pkg::MOD_AM),
      .value      (aux)
   );

   // read data registered at the setup cycle so it is stable in access
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            TYPE_BF_ADDR: prdata <= {24'h0, typeBf};
            STREAM_ADDR:  prdata <= {24'h0, stream};
            AUX_ADDR:     prdata <= {24'h0, aux};
            STATUS_ADDR:
               prdata <= {22'h0, eofMaxEtu, rxCrcCheck, crcToFifo,
                          antennaDriverTristate, subcarrierValid,
                          txPeriodValid, 1'b0};
            default:                          prdata <= 32'h0000_0000;
         endcase
      end
   end

   // receive framing decode
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         minResponseTime    <= framing_opts_pkg::TR1_LONG;
         expectSof          <= 1'b1;
         expectEof          <= 1'b1;
         phaseToleranceWide <= 1'b0;
         preambleLength     <= framing_opts_pkg::PRE_BASE;
      end else begin
         // unused codes keep the safe longer response time
         if (typeBf[framing_opts_pkg::TR1_HI:framing_opts_pkg::TR1_LO]
             == 2'b01) begin
            minResponseTime <= (rxRate == framing_opts_pkg::RATE_128)
                               ? framing_opts_pkg::TR1_MID
                               : framing_opts_pkg::TR1_SHORT;
         end else begin
            minResponseTime <= framing_opts_pkg::TR1_LONG;
         end
         expectSof <= !typeBf[framing_opts_pkg::NO_SOF];
         expectEof <= !typeBf[framing_opts_pkg::NO_EOF];
         phaseToleranceWide <= typeBf[framing_opts_pkg::PHC_BIT];
         preambleLength <= framing_opts_pkg::PRE_BASE
            + framing_opts_pkg::PRE_STEP
            * 7'(typeBf[framing_opts_pkg::PRE_HI:framing_opts_pkg::PRE_LO]);
      end
   end

   edge_decode uEof (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .eofExtend (typeBf[framing_opts_pkg::EOF_EXT]),
      .rate      (rxRate),
      .eofMaxEtu (eofMaxEtu)
   );

   // stream mode decode
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         subcarrierDivLog2 <= framing_opts_pkg::DIV_64;
         subcarrierValid   <= 1'b1;
         reportPulses      <= 4'd1;
         txPeriodDivLog2   <= framing_opts_pkg::DIV_128;
         txPeriodValid     <= 1'b1;
      end else begin
         if (bpskMode) begin
            subcarrierDivLog2 <= framing_opts_pkg::DIV_16;
            subcarrierValid   <= stream[framing_opts_pkg::SCF_HI:
                                        framing_opts_pkg::SCF_LO] == 2'b00;
         end else begin
            subcarrierDivLog2 <= framing_opts_pkg::DIV_64
               - 3'(stream[framing_opts_pkg::SCF_HI:
                           framing_opts_pkg::SCF_LO]);
            subcarrierValid   <= stream[framing_opts_pkg::SCF_HI:
                                        framing_opts_pkg::SCF_LO] != 2'b11;
         end
         // one pulse per period is legal only with bpsk; the decode gives one pulse in either mode and flags nothing
         reportPulses <= 4'd1 << stream[framing_opts_pkg::SCP_HI:
                                        framing_opts_pkg::SCP_LO];
         txPeriodDivLog2 <= framing_opts_pkg::DIV_128
            - stream[framing_opts_pkg::STX_HI:framing_opts_pkg::STX_LO];
         txPeriodValid <= !stream[framing_opts_pkg::STX_HI];
      end
   end

   // auxiliary decode
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rxCrcCheck            <= 1'b1;
         crcToFifo             <= 1'b0;
         modulationAm          <= 1'b0;
         fieldDetectorOn       <= 1'b0;
         antennaDriverTristate <= 1'b0;
         bpskTolerant          <= 1'b0;
         firstByteTolerant     <= 1'b0;
         fieldOnParameter      <= 2'b00;
      end else begin
         rxCrcCheck <= !aux[framing_opts_pkg::SKIP_CRC]
                       && !reqaWupaSent && !antiCollision;
         crcToFifo <= aux[framing_opts_pkg::CRC_BUF];
         modulationAm <= aux[framing_opts_pkg::MOD_AM];
         fieldDetectorOn <= aux[framing_opts_pkg::FD_EN];
         antennaDriverTristate <= aux[framing_opts_pkg::OOK_TRI]
                                  && ookActive
                                  && !aux[framing_opts_pkg::MOD_AM];
         bpskTolerant <= aux[framing_opts_pkg::RX_TOL] && bpskMode
                         && rxRate == framing_opts_pkg::RATE_32;
         firstByteTolerant <= aux[framing_opts_pkg::RX_TOL] && !bpskMode
                         && rxRate == framing_opts_pkg::RATE_128;
         fieldOnParameter <= aux[framing_opts_pkg::FON_HI:
                                 framing_opts_pkg::FON_LO];
      end
   end

   // command steps that the checks below are built from
   sequence s_preset_alone;
      analogPresetCmd && !wrAux && !setDefaultCmd;
   endsequence
   sequence s_tr1_fast;
      typeBf[framing_opts_pkg::TR1_HI:framing_opts_pkg::TR1_LO] == 2'b01
      && rxRate != framing_opts_pkg::RATE_128;
   endsequence
   sequence s_tr1_slow;
      typeBf[framing_opts_pkg::TR1_HI:framing_opts_pkg::TR1_LO] == 2'b01
      && rxRate == framing_opts_pkg::RATE_128;
   endsequence

   a_default_restore: assert property (@(posedge core_clk)
      disable iff (sys_rst) setDefaultCmd |=>
         aux == framing_opts_pkg::AUX_RESET
         && typeBf == framing_opts_pkg::TYPE_BF_RESET
         && stream == framing_opts_pkg::STREAM_RESET)
      else $error("set-default did not restore defaults");
   a_stream_top_zero: assert property (@(posedge core_clk)
      disable iff (sys_rst) !stream[7])
      else $error("stream bit seven set");
   a_crc_forced_off: assert property (@(posedge core_clk)
      disable iff (sys_rst) (reqaWupaSent || antiCollision) |=> !rxCrcCheck)
      else $error("crc check left on for reqa or anticollision");
   a_skip_crc_bit: assert property (@(posedge core_clk)
      disable iff (sys_rst) aux[framing_opts_pkg::SKIP_CRC] |=> !rxCrcCheck)
      else $error("crc check despite skip bit");
   a_tristate_ook: assert property (@(posedge core_clk)
      disable iff (sys_rst) antennaDriverTristate |-> $past(ookActive))
      else $error("tristate outside ook");
   a_eof_fast_rate: assert property (@(posedge core_clk)
      disable iff (sys_rst) $past(rxRate) == framing_opts_pkg::RATE_16
      |-> eofMaxEtu == framing_opts_pkg::EOF_MAX)
      else $error("eof extension active at fc/16");
   a_tr1_short: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      s_tr1_fast |=> minResponseTime == framing_opts_pkg::TR1_SHORT)
      else $error("wrong minimum response time");
   a_preamble_len: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      typeBf[framing_opts_pkg::PRE_HI:framing_opts_pkg::PRE_LO] == 2'b11
      |=> preambleLength == 7'd96)
      else $error("wrong preamble length");
   a_tr1_mid: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      s_tr1_slow |=> minResponseTime == framing_opts_pkg::TR1_MID)
      else $error("wrong minimum response time at fc/128");
   a_tr1_long: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      typeBf[framing_opts_pkg::TR1_HI:framing_opts_pkg::TR1_LO] != 2'b01
      |=> minResponseTime == framing_opts_pkg::TR1_LONG)
      else $error("long minimum response time not selected");
   a_sof_dropped: assert property (@(posedge core_clk)
      disable iff (sys_rst) typeBf[framing_opts_pkg::NO_SOF] |=> !expectSof)
      else $error("start-of-frame still expected");
   a_eof_dropped: assert property (@(posedge core_clk)
      disable iff (sys_rst) typeBf[framing_opts_pkg::NO_EOF] |=> !expectEof)
      else $error("end-of-frame still expected");
   a_eof_extended: assert property (@(posedge core_clk)
      disable iff (sys_rst) typeBf[framing_opts_pkg::EOF_EXT]
      && rxRate != framing_opts_pkg::RATE_16
      |=> eofMaxEtu == framing_opts_pkg::EOF_MAX_X)
      else $error("extended card eof not accepted");
   a_phase_wide: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      typeBf[framing_opts_pkg::PHC_BIT] |=> phaseToleranceWide)
      else $error("phase tolerance not widened");
   a_sub_bpsk: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      bpskMode |=> subcarrierDivLog2 == framing_opts_pkg::DIV_16)
      else $error("bpsk sub-carrier not fc/16");
   a_report_single: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      stream[framing_opts_pkg::SCP_HI:framing_opts_pkg::SCP_LO] == 2'b00
      |=> reportPulses == 4'd1)
      else $error("report period not one pulse");
   a_tx_unused: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      stream[framing_opts_pkg::STX_HI] |=> !txPeriodValid)
      else $error("unused transmit period flagged valid");
   a_crc_to_fifo: assert property (@(posedge core_clk)
      disable iff (sys_rst) aux[framing_opts_pkg::CRC_BUF] |=> crcToFifo)
      else $error("crc bytes not routed to fifo");
   a_preset_am: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      s_preset_alone |=> aux[framing_opts_pkg::MOD_AM] == $past(presetAm))
      else $error("analog preset did not load modulation type");
   a_detector_on: assert property (@(posedge core_clk)
      disable iff (sys_rst) aux[framing_opts_pkg::FD_EN] |=> fieldDetectorOn)
      else $error("field detector not enabled");
   a_tolerant_bpsk: assert property (@(posedge core_clk)
      disable iff (sys_rst) aux[framing_opts_pkg::RX_TOL] && bpskMode
      && rxRate == framing_opts_pkg::RATE_32 |=> bpskTolerant)
      else $error("bpsk decoder not tolerant");
   a_tolerant_first: assert property (@(posedge core_clk)
      disable iff (sys_rst) aux[framing_opts_pkg::RX_TOL] && !bpskMode
      && rxRate == framing_opts_pkg::RATE_128 |=> firstByteTolerant)
      else $error("first byte not handled tolerantly");
   a_field_on_param: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      1'b1 |=> fieldOnParameter == $past(aux[framing_opts_pkg::FON_HI:
                                              framing_opts_pkg::FON_LO]))
      else $error("field-on parameter mismatch");
endmodule : nfc_framing_option_registers

// [apb_host_model.sv]
module apb_host_model (
   input  wire logic        core_clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
   end
   // request held until pready is seen high; the bench timeout ends a hang
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic err);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : apb_host_model

// [nfc_framing_option_registers_tb_top.sv]
module nfc_framing_option_registers_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0]  pstrb, eofMaxEtu, reportPulses;
   logic setDefaultCmd, analogPresetCmd, presetAm, reqaWupaSent;
   logic antiCollision, bpskMode, ookActive, errv;
   framing_opts_pkg::bit_rate_t rxRate;
   logic [6:0] minResponseTime, preambleLength;
   logic [2:0] subcarrierDivLog2, txPeriodDivLog2;
   logic [1:0] fieldOnParameter;
   logic expectSof, expectEof, phaseToleranceWide, subcarrierValid;
   logic txPeriodValid, rxCrcCheck, crcToFifo, modulationAm;
   logic fieldDetectorOn, antennaDriverTristate, bpskTolerant;
   logic firstByteTolerant;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [7:0] d;
   apb_host_model host_u (.*);
   nfc_framing_option_registers dut_u (.*);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // decoded outputs lag the register by one edge, so two edges are waited
   // both tasks take a register index and put its byte address on the bus
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      host_u.xfer(1'b1, a << framing_opts_pkg::WORD_SHIFT, {24'h0, v},
                  rdv, errv);
      repeat (2) @(posedge core_clk);
      #1;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      host_u.xfer(1'b0, a << framing_opts_pkg::WORD_SHIFT, 32'h0,
                  rdv, errv);
   endtask : rd
   task automatic test_reset();
      rd(framing_opts_pkg::TYPE_BF_OFFSET);
      chk(rdv, 32'h0);
      rd(framing_opts_pkg::STREAM_OFFSET);
      chk(rdv, 32'h0);
      rd(framing_opts_pkg::AUX_OFFSET);
      chk(rdv, 32'h4);
      chk(minResponseTime, 80);
      chk(preambleLength, 48);
      chk(rxCrcCheck, 1);
      $display("test reset done");
   endtask : test_reset
   task automatic test_type_bf();
      for (int c = 0; c < 32; c++) begin
         @(posedge core_clk) rxRate <= framing_opts_pkg::bit_rate_t'(c[1:0]);
         d = {c[3:2], c[2], c[3], c[4], c[1], c[1:0]};
         wr(framing_opts_pkg::TYPE_BF_OFFSET, d);
         chk(minResponseTime, c[3:2] != 1 ? 80 : (c[1:0] == 0 ? 64 : 32));
         chk(expectSof, !c[2]);
         chk(expectEof, !c[3]);
         chk(eofMaxEtu, (c[4] && c[1:0] != 3) ? 12 : 11);
         chk(phaseToleranceWide, c[1]);
         chk(preambleLength, 48 + 16 * c[1:0]);
         rd(framing_opts_pkg::TYPE_BF_OFFSET);
         chk(rdv, {24'h0, d});
      end
      $display("test type b/f done");
   endtask : test_type_bf
   task automatic test_stream();
      wr(framing_opts_pkg::STREAM_OFFSET, 8'hff);
      rd(framing_opts_pkg::STREAM_OFFSET);
      chk(rdv, 32'h7f);
      for (int c = 0; c < 128; c++) begin
         @(posedge core_clk) bpskMode <= c[2];
         wr(framing_opts_pkg::STREAM_OFFSET, {1'b0, c[1:0], c[3:2], c[6:4]});
         chk(subcarrierValid, c[2] ? c[1:0] == 0 : c[1:0] != 3);
         if (c[2] ? c[1:0] == 0 : c[1:0] != 3)
            chk(subcarrierDivLog2, c[2] ? 4 : 6 - c[1:0]);
         chk(reportPulses, 1 << c[3:2]);
         chk(txPeriodValid, !c[6]);
         if (!c[6]) chk(txPeriodDivLog2, 7 - c[5:4]);
      end
      $display("test stream done");
   endtask : test_stream
   task automatic test_aux();
      for (int c = 0; c < 256; c++) begin
         @(posedge core_clk);
         ookActive <= c[0] ^ c[3];
         reqaWupaSent <= c[1] & ~c[7];
         antiCollision <= c[0] & c[6] & ~c[7];
         bpskMode <= c[0];
         rxRate <= c[0] ? framing_opts_pkg::RATE_32
                        : framing_opts_pkg::RATE_128;
         wr(framing_opts_pkg::AUX_OFFSET, c[7:0]);
         chk(rxCrcCheck, !(c[7] | (c[1] & ~c[7]) | (c[0] & c[6] & ~c[7])));
         chk(crcToFifo, c[6]);
         chk(modulationAm, c[5]);
         chk(fieldDetectorOn, c[4]);
         chk(antennaDriverTristate, c[3] & (c[0] ^ c[3]) & ~c[5]);
         if (c[0]) chk(bpskTolerant, c[2]);
         else chk(firstByteTolerant, c[2]);
         chk(fieldOnParameter, c[1:0]);
      end
      wr(framing_opts_pkg::AUX_OFFSET, 8'h00);
      @(posedge core_clk);
      analogPresetCmd <= 1'b1;
      presetAm <= 1'b1;
      @(posedge core_clk) analogPresetCmd <= 1'b0;
      repeat (2) @(posedge core_clk);
      rd(framing_opts_pkg::AUX_OFFSET);
      chk(rdv, 32'h20);
      wr(framing_opts_pkg::AUX_OFFSET, 8'h00);
      chk(modulationAm, 0);
      $display("test aux done");
   endtask : test_aux
   task automatic test_default();
      wr(framing_opts_pkg::TYPE_BF_OFFSET, 8'hff);
      wr(framing_opts_pkg::STREAM_OFFSET, 8'hff);
      wr(framing_opts_pkg::AUX_OFFSET, 8'hfb);
      rd(12'h00c);
      chk(errv, 1);
      rd(framing_opts_pkg::AUX_OFFSET);
      chk(errv, 0);
      chk(rdv, 32'hfb);
      @(posedge core_clk) setDefaultCmd <= 1'b1;
      @(posedge core_clk) setDefaultCmd <= 1'b0;
      rd(framing_opts_pkg::TYPE_BF_OFFSET);
      chk(rdv, 32'h0);
      rd(framing_opts_pkg::STREAM_OFFSET);
      chk(rdv, 32'h0);
      rd(framing_opts_pkg::AUX_OFFSET);
      chk(rdv, 32'h4);
      // bpsk at fc/32 is left over from the auxiliary test
      rd(framing_opts_pkg::STATUS_OFFSET);
      chk(rdv, {22'h0, 4'd11, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0});
      $display("test default done");
   endtask : test_default
   initial begin
      sys_rst = 1'b1;
      {setDefaultCmd, analogPresetCmd, presetAm, reqaWupaSent} = 4'h0;
      {antiCollision, bpskMode, ookActive} = 3'h0;
      rxRate = framing_opts_pkg::RATE_128;
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1;
      test_reset();
      test_type_bf();
      test_stream();
      test_aux();
      test_default();
      summarize();
   end
endmodule : nfc_framing_option_registers_tb_top
